// *** uete_defs.svh ***
// constants for the endpoint transaction engine
// How it works
// - IN token gets data when buffer holds max-packet or short packets enabled
// - firmware enables short/zero-length packets per endpoint, EP0 IN included
// - EP0 IN forced NAK sets when a short-packet IN completes
// - host ACK completes IN: ack status, bytes released from buffer
// - missing ACK raises IN error status, buffer unchanged for retry
// - too little data, no short enable: NAK, IN NAK status, buffer kept
// - PING handled only on bulk OUT endpoints in high-speed mode
// - free space above max-packet: PING gets ACK, no status
// - free space below max-packet: PING gets NAK, OUT NAK status
// - PING never changes buffer state
// - EP0 transfers run per transaction; SetAddress handled automatically
// - opposite-direction transaction marks status stage, seen through NAK status
// - status after OUT data: zero-length IN; after IN data: ACK OUT
// - SETUP to own address runs without firmware
// - after setup other than SetAddress, forced NAK and protect are set; firmware sets next stage
// - hardware decodes SetAddress and goes to status stage silently
// - SetAddress status done: load address, raise address set done status
// - data and status stages use NAK flow control until firmware ready
// - SETUP stores eight bytes, ACKs, raises setup status except SetAddress
// - setup completion: forced NAK set, stall cleared, toggle set, protect set; SetAddress clears EP0 IN forced NAK and protect
`ifndef UETE_DEFS_SVH
`define UETE_DEFS_SVH
`define UETE_ADDR_W       4
`define UETE_A_STATUS     4'h0
`define UETE_A_EP0_CTRL   4'h1
`define UETE_A_EP0_IN     4'h2
`define UETE_A_EP0_OUT    4'h3
`define UETE_A_EP_CTRL    4'h4
`define UETE_A_SETUP_LO   4'h5
`define UETE_A_SETUP_HI   4'h6
`define UETE_A_ADDRESS    4'h7
`define UETE_A_MAXPKT     4'h8
`define UETE_A_LEVEL      4'h9
// status bits, write one to clear
`define UETE_ST_IN_ACK    0
`define UETE_ST_IN_ERR    1
`define UETE_ST_IN_NAK    2
`define UETE_ST_OUT_NAK   3
`define UETE_ST_SETUP     4
`define UETE_ST_ADDR_DONE 5
`define UETE_ST_W         6
// endpoint control fields
`define UETE_C_FNAK       0
`define UETE_C_STALL      1
`define UETE_C_SHORT      2
`define UETE_C_TOGGLE     3
`define UETE_C_W          4
// ep0 common control bits
`define UETE_E_DIR        0
`define UETE_E_PROTECT    1
`define UETE_REQ_SETADDR  8'h05
`define UETE_MAXPKT_RST   11'h040
`endif

// *** uete_pkg.sv ***
// types for the endpoint transaction engine
package uete_pkg;
  typedef enum logic [2:0] {
    UETE_TOK_NONE,
    UETE_TOK_SETUP,
    UETE_TOK_IN,
    UETE_TOK_OUT,
    UETE_TOK_PING
  } uete_tok_t;
  typedef enum logic [1:0] {
    UETE_HS_NONE,
    UETE_HS_ACK,
    UETE_HS_NAK,
    UETE_HS_STALL
  } uete_hs_t;
  typedef enum {
    UETE_IDLE,
    UETE_WAIT_HS
  } uete_state_t;
endpackage : uete_pkg

// *** uete_engine.sv ***
// endpoint transaction engine: IN, PING and EP0 control sequencing
`timescale 1ns/100ps
`include "uete_defs.svh"
module uete_engine #(
  parameter int LEN_W = 11
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  // token side, from the packet layer on the same clock
  input  wire logic                    tok_valid,
  input  wire uete_pkg::uete_tok_t     tok_kind,
  input  wire logic                    tok_ep0,
  input  wire logic                    tok_addr_ok,
  input  wire logic                    high_speed,
  input  wire logic                    ep_is_bulk,
  input  wire logic                    setup_done,
  input  wire logic                    setup_ok,
  input  wire logic [63:0]             setup_data,
  input  wire logic                    host_ack,
  input  wire logic                    host_timeout,
  // answer toward the packet layer
  output logic                         hs_valid,
  output uete_pkg::uete_hs_t           hs_kind,
  output logic                         data_send,
  output logic [LEN_W-1:0]             data_len,
  output logic                         data_toggle,
  // buffer levels and release
  input  wire logic [LEN_W-1:0]        in_level,
  input  wire logic [LEN_W-1:0]        ep0_level,
  input  wire logic [LEN_W-1:0]        out_free,
  output logic                         buf_release,
  output logic                         buf_release_ep0,
  output logic [LEN_W-1:0]             release_len,
  // register port
  input  wire logic [`UETE_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic [31:0]                  reg_rdata,
  output logic [6:0]                   usb_address
);
  logic [`UETE_ST_W-1:0] status_reg;
  logic [`UETE_ST_W-1:0] status_set;
  logic [`UETE_C_W-1:0]  ep0_in_control;
  logic [`UETE_C_W-1:0]  ep0_out_control;
  logic [`UETE_C_W-1:0]  ep_control;
  logic [1:0]            ep0_common_control;
  logic [63:0]           setup_byte_regs;
  logic [LEN_W-1:0]      maxpkt_reg;
  logic [LEN_W-1:0]      ep0_maxpkt_reg;
  logic                  addr_pending_reg;
  logic [6:0]            new_addr_reg;
  uete_pkg::uete_state_t state_reg;
  logic                  pend_ep0_reg;
  logic                  pend_short_reg;
  logic [LEN_W-1:0]      pend_len_reg;
  logic                  is_setaddr;
  logic                  in_ep0;
  logic [`UETE_C_W-1:0]  in_ctl;
  logic [LEN_W-1:0]      in_lvl;
  logic [LEN_W-1:0]      in_max;
  logic                  in_ready;
  logic                  ep0_short_done;
  logic                  ep_short_done;
  logic                  take;
  logic                  wr_st;

  // request type 00h, request 05h, address below 128, no data stage
  assign is_setaddr = (setup_data[7:0] == 8'h00)
                   && (setup_data[15:8] == `UETE_REQ_SETADDR)
                   && (setup_data[31:23] == 9'h000)
                   && (setup_data[63:48] == 16'h0000);

  assign in_ep0   = tok_ep0;
  assign in_ctl   = in_ep0 ? ep0_in_control : ep_control;
  assign in_lvl   = in_ep0 ? ep0_level : in_level;
  assign in_max   = in_ep0 ? ep0_maxpkt_reg : maxpkt_reg;
  assign in_ready = (in_lvl >= in_max) || in_ctl[`UETE_C_SHORT];
  assign take     = tok_valid && tok_addr_ok && (state_reg == uete_pkg::UETE_IDLE);

  // handshake and data answer, combinational per strobe
  always_comb begin
    hs_valid  = 1'b0;
    hs_kind   = uete_pkg::UETE_HS_NONE;
    data_send = 1'b0;
    if (take) begin
      case (tok_kind)
        uete_pkg::UETE_TOK_SETUP: begin
          if (setup_done && setup_ok) begin
            hs_valid = 1'b1;
            hs_kind  = uete_pkg::UETE_HS_ACK;
          end
        end
        uete_pkg::UETE_TOK_IN: begin
          if (in_ctl[`UETE_C_STALL]) begin
            hs_valid = 1'b1;
            hs_kind  = uete_pkg::UETE_HS_STALL;
          end else if (in_ctl[`UETE_C_FNAK] || !in_ready
                       || (in_ep0 && ep0_common_control[`UETE_E_PROTECT])) begin
            hs_valid = 1'b1;
            hs_kind  = uete_pkg::UETE_HS_NAK;
          end else begin
            data_send = 1'b1;
          end
        end
        uete_pkg::UETE_TOK_OUT: begin
          // only the EP0 status OUT is answered here; OUT data lives elsewhere
          if (in_ep0) begin
            hs_valid = 1'b1;
            if (ep0_out_control[`UETE_C_STALL])
              hs_kind = uete_pkg::UETE_HS_STALL;
            else if (ep0_out_control[`UETE_C_FNAK] || ep0_common_control[`UETE_E_PROTECT])
              hs_kind = uete_pkg::UETE_HS_NAK;
            else
              hs_kind = uete_pkg::UETE_HS_ACK;
          end
        end
        uete_pkg::UETE_TOK_PING: begin
          if (high_speed && ep_is_bulk && !in_ep0) begin
            hs_valid = 1'b1;
            if (ep_control[`UETE_C_STALL])
              hs_kind = uete_pkg::UETE_HS_STALL;
            else if (!ep_control[`UETE_C_FNAK] && out_free > maxpkt_reg)
              hs_kind = uete_pkg::UETE_HS_ACK;
            else
              hs_kind = uete_pkg::UETE_HS_NAK;
          end
        end
        default: begin
          hs_valid = 1'b0;
        end
      endcase
    end
  end

  always_comb begin
    data_len    = (in_lvl >= in_max) ? in_max : in_lvl;
    data_toggle = in_ctl[`UETE_C_TOGGLE];
  end

  // pending IN transaction waiting for the host handshake
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= uete_pkg::UETE_IDLE;
      pend_ep0_reg   <= 1'b0;
      pend_short_reg <= 1'b0;
      pend_len_reg   <= '0;
    end else begin
      case (state_reg)
        uete_pkg::UETE_IDLE: begin
          if (data_send) begin
            state_reg      <= uete_pkg::UETE_WAIT_HS;
            pend_ep0_reg   <= in_ep0;
            pend_short_reg <= (data_len < in_max);
            pend_len_reg   <= data_len;
          end
        end
        uete_pkg::UETE_WAIT_HS: begin
          if (host_ack || host_timeout)
            state_reg <= uete_pkg::UETE_IDLE;
        end
        default: state_reg <= uete_pkg::UETE_IDLE;
      endcase
    end
  end

  // buffer is only touched on an acknowledged IN
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buf_release     <= 1'b0;
      buf_release_ep0 <= 1'b0;
      release_len     <= '0;
    end else begin
      buf_release     <= (state_reg == uete_pkg::UETE_WAIT_HS) && host_ack;
      buf_release_ep0 <= pend_ep0_reg;
      release_len     <= pend_len_reg;
    end
  end

  assign ep0_short_done = (state_reg == uete_pkg::UETE_WAIT_HS) && host_ack && pend_ep0_reg
                          && pend_short_reg;
  assign ep_short_done  = (state_reg == uete_pkg::UETE_WAIT_HS) && host_ack && !pend_ep0_reg
                          && pend_short_reg;

  // sticky events; a set in the same cycle as its clear wins
  always_comb begin
    status_set = '0;
    if (state_reg == uete_pkg::UETE_WAIT_HS && host_ack)
      status_set[`UETE_ST_IN_ACK] = 1'b1;
    if (state_reg == uete_pkg::UETE_WAIT_HS && host_timeout && !host_ack)
      status_set[`UETE_ST_IN_ERR] = 1'b1;
    if (hs_valid && hs_kind == uete_pkg::UETE_HS_NAK && tok_kind == uete_pkg::UETE_TOK_IN)
      status_set[`UETE_ST_IN_NAK] = 1'b1;
    if (hs_valid && hs_kind == uete_pkg::UETE_HS_NAK && (tok_kind == uete_pkg::UETE_TOK_PING
        || tok_kind == uete_pkg::UETE_TOK_OUT))
      status_set[`UETE_ST_OUT_NAK] = 1'b1;
    if (take && tok_kind == uete_pkg::UETE_TOK_SETUP && setup_done && setup_ok && !is_setaddr)
      status_set[`UETE_ST_SETUP] = 1'b1;
    if (addr_pending_reg && take && tok_ep0 && data_send)
      status_set[`UETE_ST_ADDR_DONE] = 1'b0;
    if (addr_pending_reg && state_reg == uete_pkg::UETE_WAIT_HS && host_ack && pend_ep0_reg)
      status_set[`UETE_ST_ADDR_DONE] = 1'b1;
  end

  assign wr_st = reg_wr && (reg_addr == `UETE_A_STATUS);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      status_reg <= '0;
    else
      status_reg <= (status_reg & ~(wr_st ? reg_wdata[`UETE_ST_W-1:0] : '0)) | status_set;
  end

  // setup bytes and automatic SetAddress
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      setup_byte_regs  <= '0;
      addr_pending_reg <= 1'b0;
      new_addr_reg     <= '0;
      usb_address      <= '0;
    end else begin
      if (take && tok_kind == uete_pkg::UETE_TOK_SETUP && setup_done && setup_ok) begin
        setup_byte_regs  <= setup_data;
        addr_pending_reg <= is_setaddr;
        new_addr_reg     <= setup_data[22:16];
      end else if (addr_pending_reg && state_reg == uete_pkg::UETE_WAIT_HS && host_ack
                   && pend_ep0_reg) begin
        usb_address      <= new_addr_reg;
        addr_pending_reg <= 1'b0;
      end
    end
  end

  // endpoint controls: software writes, hardware sets on setup and short completion
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ep0_in_control     <= '0;
      ep0_out_control    <= '0;
      ep_control         <= '0;
      ep0_common_control <= '0;
      maxpkt_reg         <= LEN_W'(`UETE_MAXPKT_RST);
      ep0_maxpkt_reg     <= LEN_W'(`UETE_MAXPKT_RST);
    end else begin
      if (reg_wr && reg_addr == `UETE_A_EP0_IN)
        ep0_in_control <= reg_wdata[`UETE_C_W-1:0];
      if (reg_wr && reg_addr == `UETE_A_EP0_OUT)
        ep0_out_control <= reg_wdata[`UETE_C_W-1:0];
      if (reg_wr && reg_addr == `UETE_A_EP_CTRL)
        ep_control <= reg_wdata[`UETE_C_W-1:0];
      if (reg_wr && reg_addr == `UETE_A_EP0_CTRL)
        ep0_common_control <= reg_wdata[1:0];
      if (reg_wr && reg_addr == `UETE_A_MAXPKT) begin
        maxpkt_reg     <= reg_wdata[LEN_W-1:0];
        ep0_maxpkt_reg <= reg_wdata[16+LEN_W-1:16];
      end
      if (ep0_short_done) begin
        ep0_in_control[`UETE_C_FNAK]  <= 1'b1;
        ep0_in_control[`UETE_C_SHORT] <= 1'b0;
      end
      if (ep_short_done)
        ep_control[`UETE_C_SHORT] <= 1'b0;
      if (state_reg == uete_pkg::UETE_WAIT_HS && host_ack) begin
        if (pend_ep0_reg)
          ep0_in_control[`UETE_C_TOGGLE] <= ~ep0_in_control[`UETE_C_TOGGLE];
        else
          ep_control[`UETE_C_TOGGLE] <= ~ep_control[`UETE_C_TOGGLE];
      end
      if (take && tok_kind == uete_pkg::UETE_TOK_SETUP && setup_done && setup_ok) begin
        // setup wins over a software write to the bits it sets in the same cycle
        ep0_in_control[`UETE_C_FNAK]    <= ~is_setaddr;
        ep0_in_control[`UETE_C_STALL]   <= 1'b0;
        ep0_in_control[`UETE_C_TOGGLE]  <= 1'b1;
        ep0_in_control[`UETE_C_SHORT]   <= is_setaddr;
        ep0_out_control[`UETE_C_FNAK]   <= 1'b1;
        ep0_out_control[`UETE_C_STALL]  <= 1'b0;
        ep0_out_control[`UETE_C_TOGGLE] <= 1'b1;
        ep0_common_control[`UETE_E_PROTECT] <= ~is_setaddr;
        ep0_common_control[`UETE_E_DIR]     <= is_setaddr ? 1'b1
                                               : ep0_common_control[`UETE_E_DIR];
      end
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `UETE_A_STATUS:   reg_rdata <= 32'(status_reg);
        `UETE_A_EP0_CTRL: reg_rdata <= 32'(ep0_common_control);
        `UETE_A_EP0_IN:   reg_rdata <= 32'(ep0_in_control);
        `UETE_A_EP0_OUT:  reg_rdata <= 32'(ep0_out_control);
        `UETE_A_EP_CTRL:  reg_rdata <= 32'(ep_control);
        `UETE_A_SETUP_LO: reg_rdata <= setup_byte_regs[31:0];
        `UETE_A_SETUP_HI: reg_rdata <= setup_byte_regs[63:32];
        `UETE_A_ADDRESS:  reg_rdata <= 32'(usb_address);
        `UETE_A_MAXPKT:   reg_rdata <= {5'h00, ep0_maxpkt_reg, 5'h00, maxpkt_reg};
        `UETE_A_LEVEL:    reg_rdata <= {5'h00, ep0_level, 5'h00, in_level};
        default:          reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule : uete_engine

// *** uete_engine_props.sv ***
// port checker for the endpoint transaction engine
`timescale 1ns/100ps
module uete_engine_props #(
  parameter int LEN_W = 11
) (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic                tok_valid,
  input wire uete_pkg::uete_tok_t tok_kind,
  input wire logic                tok_ep0,
  input wire logic                tok_addr_ok,
  input wire logic                high_speed,
  input wire logic                ep_is_bulk,
  input wire logic                setup_done,
  input wire logic                setup_ok,
  input wire logic                host_ack,
  input wire logic                host_timeout,
  input wire logic                hs_valid,
  input wire uete_pkg::uete_hs_t  hs_kind,
  input wire logic                data_send,
  input wire logic [LEN_W-1:0]    data_len,
  input wire logic                buf_release,
  input wire logic                buf_release_ep0,
  input wire logic [LEN_W-1:0]    release_len,
  input wire logic [6:0]          usb_address
);
  logic             wait_q;
  logic             ep0_q;
  logic [LEN_W-1:0] len_q;
  logic             is_ping;
  logic             rel;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  assign is_ping = tok_valid && tok_addr_ok && tok_kind == uete_pkg::UETE_TOK_PING;
  // the ep0 qualifier is a level, only the strobe means bytes go
  assign rel     = buf_release;
  // data sent, handshake not yet seen
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b0;
      ep0_q  <= 1'b0;
      len_q  <= '0;
    end else if (data_send) begin
      wait_q <= 1'b1;
      ep0_q  <= tok_ep0;
      len_q  <= data_len;
    end else if (host_ack || host_timeout) begin
      wait_q <= 1'b0;
    end
  end
  AST_NO_ADDR: assert property (
    tok_valid && !tok_addr_ok |-> !hs_valid && !data_send)
    else $error("answer to foreign token");
  AST_PING_GATE: assert property (
    is_ping && !(high_speed && ep_is_bulk && !tok_ep0) |-> !hs_valid)
    else $error("ping answered outside bulk high speed");
  AST_PING_ANS: assert property (
    is_ping && !wait_q && high_speed && ep_is_bulk && !tok_ep0
    |-> hs_valid && !data_send && hs_kind inside {uete_pkg::UETE_HS_ACK, uete_pkg::UETE_HS_NAK})
    else $error("ping not answered by handshake");
  AST_PING_BUF: assert property (is_ping && !host_ack |=> !rel)
    else $error("ping touched buffer");
  AST_ERR_KEEP: assert property (host_timeout |=> !rel)
    else $error("buffer released without ack");
  AST_ACK_REL: assert property (host_ack && wait_q && len_q != '0
    |=> rel && release_len == len_q && buf_release_ep0 == ep0_q)
    else $error("acked bytes not released");
  AST_NAK_DATA: assert property (data_send |-> !hs_valid)
    else $error("data and handshake together");
  AST_SETUP_ACK: assert property (
    tok_valid && tok_addr_ok && !wait_q && tok_ep0 && setup_done && setup_ok
    && tok_kind == uete_pkg::UETE_TOK_SETUP |-> hs_valid && hs_kind == uete_pkg::UETE_HS_ACK)
    else $error("setup not acked");
  AST_ADDR_LOAD: assert property (
    $changed(usb_address) |-> $past(host_ack) || $past(host_ack, 2))
    else $error("address changed without status ack");
endmodule : uete_engine_props

// *** uete_host_model.sv ***
// host model: tokens, setup packets and handshakes
`timescale 1ns/100ps
module uete_host_model (
  input  wire logic           mclk,
  input  wire logic           data_send,
  input  wire logic [3:0]     ack_delay,
  input  wire logic           drop_ack,
  output logic                tok_valid,
  output uete_pkg::uete_tok_t tok_kind,
  output logic                tok_ep0,
  output logic                tok_addr_ok,
  output logic                setup_done,
  output logic                setup_ok,
  output logic [63:0]         setup_data,
  output logic                host_ack,
  output logic                host_timeout
);
  logic [3:0] cnt = 4'h0;
  initial begin
    tok_valid = 1'b0;
    tok_kind = uete_pkg::UETE_TOK_NONE;
    {tok_ep0, tok_addr_ok, setup_done, setup_ok} = 4'h0;
    setup_data = 64'h0;
    {host_ack, host_timeout} = 2'h0;
  end
  // handshake ack_delay edges after the data packet
  always @(posedge mclk) begin
    host_ack <= 1'b0;
    host_timeout <= 1'b0;
    if (data_send) begin
      cnt <= ack_delay;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      host_ack <= cnt == 4'h1 && !drop_ack;
      host_timeout <= cnt == 4'h1 && drop_ack;
    end
  end
  // token held one cycle; returns mid-cycle so answers can be sampled
  task automatic token(input uete_pkg::uete_tok_t k, input logic e0, input logic aok,
                       input logic [63:0] sd);
    @(posedge mclk);
    tok_valid <= 1'b1;
    tok_kind <= k;
    tok_ep0 <= e0;
    tok_addr_ok <= aok;
    setup_done <= k == uete_pkg::UETE_TOK_SETUP;
    setup_ok <= k == uete_pkg::UETE_TOK_SETUP;
    setup_data <= sd;
    @(negedge mclk);
  endtask : token
  task automatic quiet();
    @(posedge mclk);
    tok_valid <= 1'b0;
    tok_kind <= uete_pkg::UETE_TOK_NONE;
    {setup_done, setup_ok} <= 2'h0;
    // released data lines must not keep the old bytes
    setup_data <= ~setup_data;
  endtask : quiet
endmodule : uete_host_model

// *** uete_engine_tb.sv ***
// self-checking bench for the endpoint transaction engine
`timescale 1ns/100ps
module uete_engine_tb;
  localparam uete_pkg::uete_tok_t TIN = uete_pkg::UETE_TOK_IN;
  localparam uete_pkg::uete_tok_t TPG = uete_pkg::UETE_TOK_PING;
  localparam uete_pkg::uete_tok_t TSU = uete_pkg::UETE_TOK_SETUP;
  localparam uete_pkg::uete_tok_t TOU = uete_pkg::UETE_TOK_OUT;
  localparam int LEN_W = 11;
  // e: {hs_valid, hs_kind, data_send, data_len}
  typedef struct {
    uete_pkg::uete_tok_t k;
    logic [2:0]          cfg;
    logic [10:0]         lvl;
    logic [10:0]         fre;
    logic [14:0]         e;
    logic [5:0]          st;
  } uete_row_t;
  uete_row_t rows [8] = '{
    '{TIN, 3'h7, 11'h040, 11'h000, 15'h0840, 6'h01},
    '{TIN, 3'h7, 11'h03F, 11'h000, 15'h6000, 6'h04},
    '{TIN, 3'h7, 11'h080, 11'h000, 15'h0840, 6'h01},
    '{TPG, 3'h7, 11'h000, 11'h041, 15'h5000, 6'h00},
    '{TPG, 3'h7, 11'h000, 11'h03F, 15'h6000, 6'h08},
    '{TPG, 3'h5, 11'h000, 11'h041, 15'h0000, 6'h00},
    '{TPG, 3'h6, 11'h000, 11'h041, 15'h0000, 6'h00},
    '{TIN, 3'h3, 11'h040, 11'h000, 15'h0000, 6'h00}};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic high_speed = 1'b1;
  logic ep_is_bulk = 1'b1;
  logic [10:0] in_level = 11'h0, ep0_level = 11'h0, out_free = 11'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, drop_ack = 1'b0;
  logic [3:0] ack_delay = 4'h1;
  logic tok_valid, tok_ep0, tok_addr_ok, setup_done, setup_ok, host_ack, host_timeout;
  uete_pkg::uete_tok_t tok_kind;
  uete_pkg::uete_hs_t hs_kind;
  logic [63:0] setup_data;
  logic hs_valid, data_send, data_toggle, buf_release, buf_release_ep0;
  logic [10:0] data_len, release_len, rel_len;
  logic [31:0] reg_rdata, rdv;
  logic [6:0] usb_address;
  logic [3:0] rel_n = 4'h0;
  logic rel_ep0 = 1'b0;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  uete_engine #(.LEN_W(LEN_W)) u_uete_engine (.mclk, .rst_n, .tok_valid, .tok_kind, .tok_ep0,
    .tok_addr_ok, .high_speed, .ep_is_bulk, .setup_done, .setup_ok, .setup_data, .host_ack,
    .host_timeout, .hs_valid, .hs_kind, .data_send, .data_len, .data_toggle, .in_level,
    .ep0_level, .out_free, .buf_release, .buf_release_ep0, .release_len, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .usb_address);
  uete_host_model u_uete_host_model (.mclk, .data_send, .ack_delay, .drop_ack, .tok_valid,
    .tok_kind, .tok_ep0, .tok_addr_ok, .setup_done, .setup_ok, .setup_data, .host_ack,
    .host_timeout);
  initial begin
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    // the ep0 flag is a level beside the strobe, not a strobe itself
    if (buf_release) begin
      rel_n <= rel_n + 4'h1;
      rel_len <= release_len;
      rel_ep0 <= buf_release_ep0;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    rdv = reg_rdata;
  endtask : rd
  task automatic stat(input logic [5:0] e);
    rd(4'h0);
    chk("status", rdv, {26'h0, e});
    wr(4'h0, 32'h3F);
  endtask : stat
  task automatic tok(input uete_pkg::uete_tok_t k, input logic [1:0] ea, input logic [63:0] sd,
                     input logic [14:0] e);
    u_uete_host_model.token(k, ea[1], ea[0], sd);
    chk("answer", {hs_valid, hs_kind, data_send, data_send ? data_len : 11'h0},
        {17'h0, e});
    u_uete_host_model.quiet();
  endtask : tok
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h8);
    chk("maxpkt", rdv, 32'h0040_0040);
    stat(6'h00);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge mclk);
      {high_speed, ep_is_bulk} <= rows[i].cfg[1:0];
      in_level <= rows[i].lvl;
      out_free <= rows[i].fre;
      rel_n = 4'h0;
      tok(rows[i].k, {1'b0, rows[i].cfg[2]}, 64'h0, rows[i].e);
      repeat (4) @(posedge mclk);
      chk("releases", rel_n, {3'h0, rows[i].e[11]});
      stat(rows[i].st);
      $display("test row %0d done", i);
    end
    // host never acks: bytes must stay for the retry
    drop_ack <= 1'b1;
    ack_delay <= 4'h6;
    in_level <= 11'h040;
    rel_n = 4'h0;
    tok(TIN, 2'h1, 64'h0, 15'h0840);
    repeat (8) @(posedge mclk);
    chk("releases", rel_n, 4'h0);
    stat(6'h02);
    drop_ack <= 1'b0;
    ack_delay <= 4'h1;
    wr(4'h4, 32'h4);
    in_level <= 11'h005;
    rel_n = 4'h0;
    tok(TIN, 2'h1, 64'h0, 15'h0805);
    // level left alone until the short packet is acked
    repeat (4) @(posedge mclk);
    chk("release", {rel_n, rel_len}, {4'h1, 11'h005});
    stat(6'h01);
    $display("test short and error done");
    tok(TSU, 2'h3, 64'h0000_0000_002A_0500, 15'h5000);
    stat(6'h00);
    tok(TIN, 2'h3, 64'h0, 15'h0800);
    repeat (4) @(posedge mclk);
    chk("address", usb_address, 7'h2A);
    rd(4'h7);
    chk("address reg", rdv[6:0], 7'h2A);
    rd(4'h0);
    chk("address done", rdv[5], 1'b1);
    wr(4'h0, 32'h3F);
    $display("test set address done");
    tok(TSU, 2'h3, 64'h0012_0000_0100_0680, 15'h5000);
    rd(4'h0);
    chk("setup flag", rdv[4], 1'b1);
    rd(4'h5);
    chk("setup bytes", rdv, 32'h0100_0680);
    rd(4'h2);
    chk("ep0 in ctl", {rdv[3], rdv[1:0]}, 3'h5);
    rd(4'h1);
    chk("protect", rdv[1], 1'b1);
    // firmware picks the IN data stage and lifts protect
    wr(4'h1, 32'h1);
    ep0_level <= 11'h040;
    tok(TIN, 2'h3, 64'h0, 15'h6000);
    wr(4'h2, 32'h8);
    tok(TIN, 2'h3, 64'h0, 15'h0840);
    // tokens are ignored until the host handshake closes the IN
    repeat (4) @(posedge mclk);
    chk("ep0 release", {rel_ep0, rel_len}, {1'b1, 11'h040});
    chk("ep0 toggle", data_toggle, 1'b0);
    tok(TOU, 2'h3, 64'h0, 15'h6000);
    wr(4'h3, 32'h8);
    tok(TOU, 2'h3, 64'h0, 15'h5000);
    rd(4'h0);
    chk("out nak", rdv[3], 1'b1);
    $display("test control transfer done");
    end_of_test();
  end
endmodule : uete_engine_tb
bind uete_engine uete_engine_props #(.LEN_W(LEN_W)) u_uete_engine_props (.mclk, .rst_n,
  .tok_valid, .tok_kind, .tok_ep0, .tok_addr_ok, .high_speed, .ep_is_bulk, .setup_done,
  .setup_ok, .host_ack, .host_timeout, .hs_valid, .hs_kind, .data_send, .data_len,
  .buf_release, .buf_release_ep0, .release_len, .usb_address);
